// [alu_pkg.sv]
// Shared constants and opcode enumeration for the execution slice
package alu_pkg;
   // Operation select presented by the decoder
   typedef enum logic [2:0] {
      op_none = 3'h0,
      subtract_with_borrow_op = 3'h1,
      nibble_exchange_op = 3'h2,
      direction_load_op = 3'h3,
      xor_immediate_op = 3'h4,
      xor_register_op = 3'h5
   } op_t;
   // Direction operand values
   localparam logic DEST_ACC = 1'h0;
   localparam logic DEST_FILE = 1'h1;
   // Direction-register selectors
   localparam logic [6:0] SEL_PORT_A = 7'h05;
   localparam logic [6:0] SEL_PORT_B = 7'h06;
   localparam logic [6:0] SEL_PORT_C = 7'h07;
   // Values after reset
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [7:0] DIR_RESET = 8'hFF;
   localparam logic FLAG_RESET = 1'h0;
   // Field positions of the nibbles
   localparam int NIB_LO = 0;
   localparam int NIB_HI = 4;
   // File register count (addresses 0 to 127)
   localparam int FILE_DEPTH = 128;
endpackage

// [file_regs.sv]
// Small file register memory with registered read data
`timescale 1ns/1ps
module file_regs (
   input wire logic clk,
   input wire logic [6:0] rd_addr,
   output logic [7:0] rd_data,
   input wire logic wr_en,
   input wire logic [6:0] wr_addr,
   input wire logic [7:0] wr_data
);
   // Storage; contents undefined after reset like real RAM
   logic [7:0] mem [alu_pkg::FILE_DEPTH];

   // Write port and registered read port
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule

// [cpu_alu_sub_swap_xor_direction_load_op.sv]
// Execution datapath: borrow subtract, nibble swap, direction load, XOR
// Behaviour
// [RULE_01] Borrow subtract: file minus acc minus not-carry
// [RULE_02] Borrow subtract updates carry, nibble carry, zero
// [RULE_03] Borrow subtract result goes by direction bit
// [RULE_04] Nibble swap exchanges halves, flags untouched
// [RULE_05] Nibble swap result goes by direction bit
// [RULE_06] Direction load copies acc to selected port
// [RULE_07] Immediate XOR into acc, zero flag only
// [RULE_08] Register XOR steered by direction, zero only
// [RULE_09] Zero flag set when result is zero
`timescale 1ns/1ps
module cpu_alu_sub_swap_xor_direction_load_op (
   input wire logic clk,
   input wire logic nrst,
   input wire logic op_valid,
   input wire alu_pkg::op_t op,
   input wire logic [6:0] file_addr,
   input wire logic dest,
   input wire logic [7:0] literal,
   output logic busy,
   output logic [7:0] accumulator,
   output logic carry_flag,
   output logic nibble_carry_flag,
   output logic zero_flag,
   output logic [7:0] port_a_direction,
   output logic [7:0] port_b_direction,
   output logic [7:0] port_c_direction,
   output logic done
);
   // Two-stage execution: fetch operand, then execute
   typedef enum logic [0:0] {
      st_idle = 1'h0,
      st_exec = 1'h1
   } state_t;

   logic rst_meta; // Reset synchroniser first stage
   logic rst_n; // Synchronised reset used everywhere
   state_t state; // Sequencer state
   state_t next_state;
   alu_pkg::op_t op_q; // Latched operation
   alu_pkg::op_t next_op_q;
   logic [6:0] addr_q; // Latched file address
   logic [6:0] next_addr_q;
   logic dest_q; // Latched direction operand
   logic next_dest_q;
   logic [7:0] lit_q; // Latched literal
   logic [7:0] next_lit_q;
   logic [7:0] next_accumulator;
   logic next_carry_flag;
   logic next_nibble_carry_flag;
   logic next_zero_flag;
   logic [7:0] next_port_a_direction;
   logic [7:0] next_port_b_direction;
   logic [7:0] next_port_c_direction;
   logic next_done;
   logic [7:0] file_data; // File register operand
   logic file_wr; // File write strobe
   logic [7:0] result; // Operation result
   logic [8:0] diff; // Full difference; bit 8 clear means no borrow
   logic [4:0] low_diff; // Low nibble difference
   logic borrow_in; // Borrow is the inverted carry

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta <= 1'h0;
         rst_n <= 1'h0;
      end else begin
         rst_meta <= 1'h1;
         rst_n <= rst_meta;
      end
   end

   // File memory; read data arrive one cycle after the address
   file_regs u_file (
      .clk(clk),
      .rd_addr(file_addr),
      .rd_data(file_data),
      .wr_en(file_wr),
      .wr_addr(addr_q),
      .wr_data(result)
   );

   // Arithmetic; borrow subtract done as two's complement
   always_comb begin
      borrow_in = ~carry_flag; // RULE_01
      diff = {1'h0, file_data} - {1'h0, accumulator}
         - {8'h00, borrow_in}; // RULE_01
      low_diff = {1'h0, file_data[3:0]} - {1'h0, accumulator[3:0]}
         - {4'h0, borrow_in}; // RULE_02
   end

   // Result select per operation
   always_comb begin
      case (op_q)
         alu_pkg::subtract_with_borrow_op: result = diff[7:0]; // RULE_01
         alu_pkg::nibble_exchange_op: begin
            result = {file_data[alu_pkg::NIB_LO +: 4],
               file_data[alu_pkg::NIB_HI +: 4]}; // RULE_04
         end
         alu_pkg::xor_immediate_op: result = accumulator ^ lit_q; // RULE_07
         alu_pkg::xor_register_op: result = accumulator ^ file_data; // RULE_08
         default: result = accumulator;
      endcase
   end

   // Next-state computation for sequencer, accumulator and flags
   always_comb begin
      next_state = state;
      next_op_q = op_q;
      next_addr_q = addr_q;
      next_dest_q = dest_q;
      next_lit_q = lit_q;
      next_accumulator = accumulator;
      next_carry_flag = carry_flag;
      next_nibble_carry_flag = nibble_carry_flag;
      next_zero_flag = zero_flag;
      next_port_a_direction = port_a_direction;
      next_port_b_direction = port_b_direction;
      next_port_c_direction = port_c_direction;
      next_done = 1'h0;
      file_wr = 1'h0;
      case (state)
         st_idle: begin
            // Accept a request; file read starts this cycle
            if (op_valid) begin
               next_op_q = op;
               next_addr_q = file_addr;
               next_dest_q = dest;
               next_lit_q = literal;
               next_state = st_exec;
            end
         end
         st_exec: begin
            next_state = st_idle;
            next_done = 1'h1;
            case (op_q)
               alu_pkg::subtract_with_borrow_op,
               alu_pkg::nibble_exchange_op,
               alu_pkg::xor_register_op: begin
                  // Destination chosen by direction operand
                  if (dest_q == alu_pkg::DEST_FILE) begin
                     file_wr = 1'h1; // RULE_03 RULE_05 RULE_08
                  end else begin
                     next_accumulator = result; // RULE_03 RULE_05 RULE_08
                  end
               end
               alu_pkg::xor_immediate_op: begin
                  next_accumulator = result; // RULE_07
               end
               alu_pkg::direction_load_op: begin
                  // Unlisted selectors load nothing
                  if (addr_q == alu_pkg::SEL_PORT_A) begin
                     next_port_a_direction = accumulator; // RULE_06
                  end
                  if (addr_q == alu_pkg::SEL_PORT_B) begin
                     next_port_b_direction = accumulator; // RULE_06
                  end
                  if (addr_q == alu_pkg::SEL_PORT_C) begin
                     next_port_c_direction = accumulator; // RULE_06
                  end
               end
               default: begin
               end
            endcase
            // Flags: carry means no borrow occurred
            if (op_q == alu_pkg::subtract_with_borrow_op) begin
               next_carry_flag = ~diff[8]; // RULE_02
               next_nibble_carry_flag = ~low_diff[4]; // RULE_02
            end
            if (op_q == alu_pkg::subtract_with_borrow_op ||
                op_q == alu_pkg::xor_immediate_op ||
                op_q == alu_pkg::xor_register_op) begin
               next_zero_flag = (result == 8'h00); // RULE_09
            end
         end
         default: next_state = st_idle;
      endcase
   end

   // Register all state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= st_idle;
         op_q <= alu_pkg::op_none;
         addr_q <= 7'h00;
         dest_q <= alu_pkg::DEST_ACC;
         lit_q <= 8'h00;
         accumulator <= alu_pkg::ACC_RESET;
         carry_flag <= alu_pkg::FLAG_RESET;
         nibble_carry_flag <= alu_pkg::FLAG_RESET;
         zero_flag <= alu_pkg::FLAG_RESET;
         port_a_direction <= alu_pkg::DIR_RESET;
         port_b_direction <= alu_pkg::DIR_RESET;
         port_c_direction <= alu_pkg::DIR_RESET;
         done <= 1'h0;
      end else begin
         state <= next_state;
         op_q <= next_op_q;
         addr_q <= next_addr_q;
         dest_q <= next_dest_q;
         lit_q <= next_lit_q;
         accumulator <= next_accumulator;
         carry_flag <= next_carry_flag;
         nibble_carry_flag <= next_nibble_carry_flag;
         zero_flag <= next_zero_flag;
         port_a_direction <= next_port_a_direction;
         port_b_direction <= next_port_b_direction;
         port_c_direction <= next_port_c_direction;
         done <= next_done;
      end
   end

   // Busy while executing; a new request waits for idle
   assign busy = (state == st_exec);

   // Execution cycle of a given operation
   sequence exec_of(alu_pkg::op_t o);
      state == st_exec && op_q == o;
   endsequence

   // Steering conditions are fused onto the execute step with ##0,
   // since a named sequence cannot be an operand of a logical and
   sub_result_a: assert property ( // RULE_01
      @(posedge clk) disable iff (!rst_n)
      exec_of(alu_pkg::subtract_with_borrow_op) ##0
      dest_q == alu_pkg::DEST_ACC |=>
      accumulator == $past(file_data) - $past(accumulator) - {7'h00,
      ~$past(carry_flag)})
      else $error("borrow subtract result wrong");
   sub_carry_a: assert property ( // RULE_02
      @(posedge clk) disable iff (!rst_n)
      exec_of(alu_pkg::subtract_with_borrow_op) |=>
      carry_flag == ({1'h0, $past(file_data)} >= {1'h0,
      $past(accumulator)} + {8'h00, ~$past(carry_flag)}))
      else $error("borrow subtract carry wrong");
   sub_dest_a: assert property ( // RULE_03
      @(posedge clk) disable iff (!rst_n)
      exec_of(alu_pkg::subtract_with_borrow_op) ##0
      dest_q == alu_pkg::DEST_FILE |->
      file_wr ##1 $stable(accumulator))
      else $error("borrow subtract destination wrong");
   swap_flags_a: assert property ( // RULE_04
      @(posedge clk) disable iff (!rst_n)
      exec_of(alu_pkg::nibble_exchange_op) |=>
      $stable(carry_flag) && $stable(zero_flag) && $stable(nibble_carry_flag))
      else $error("swap changed a flag");
   swap_acc_a: assert property ( // RULE_05
      @(posedge clk) disable iff (!rst_n)
      exec_of(alu_pkg::nibble_exchange_op) ##0
      dest_q == alu_pkg::DEST_ACC |=>
      accumulator == {$past(file_data[3:0]), $past(file_data[7:4])})
      else $error("swap result wrong");
   dir_load_a: assert property ( // RULE_06
      @(posedge clk) disable iff (!rst_n)
      exec_of(alu_pkg::direction_load_op) ##0
      addr_q == alu_pkg::SEL_PORT_B |=>
      port_b_direction == $past(accumulator) && $stable(zero_flag))
      else $error("direction load wrong");
   xor_imm_a: assert property ( // RULE_07
      @(posedge clk) disable iff (!rst_n)
      exec_of(alu_pkg::xor_immediate_op) |=>
      accumulator == ($past(accumulator) ^ $past(lit_q)) &&
      $stable(carry_flag))
      else $error("immediate xor wrong");
   xor_reg_a: assert property ( // RULE_08
      @(posedge clk) disable iff (!rst_n)
      exec_of(alu_pkg::xor_register_op) ##0
      dest_q == alu_pkg::DEST_ACC |=>
      accumulator == ($past(accumulator) ^ $past(file_data)) &&
      $stable(nibble_carry_flag))
      else $error("register xor wrong");
   zero_flag_a: assert property ( // RULE_09
      @(posedge clk) disable iff (!rst_n)
      exec_of(alu_pkg::xor_immediate_op) |=>
      zero_flag == (accumulator == 8'h00))
      else $error("zero flag wrong");
endmodule

// [tb.sv]
// Self-checking bench for the execution datapath slice
`timescale 1ns/1ps
`define CHK(got, exp) \
   begin \
      cmp_count++; \
      if ((got) !== (exp)) begin \
         error_cnt++; \
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
      end \
   end
module tb;
   logic clk = 1'h0; // 50 MHz clock
   logic nrst = 1'h0; // Active-low reset
   logic op_valid = 1'h0; // Request strobe
   alu_pkg::op_t op = alu_pkg::op_none; // Operation select
   logic [6:0] file_addr = 7'h00; // File address or selector
   logic dest = 1'h0; // Result steering
   logic [7:0] literal = 8'h00; // Immediate operand
   logic busy, carry_flag, nibble_carry_flag, zero_flag, done;
   logic [7:0] accumulator, port_a_direction, port_b_direction;
   logic [7:0] port_c_direction;
   int error_cnt = 0; // Mismatches seen
   int cmp_count = 0; // Comparisons made
   logic [7:0] exp_acc = 8'h00; // Bench copy of the accumulator
   logic exp_c = 1'h0; // Bench copy of the carry flag
   cpu_alu_sub_swap_xor_direction_load_op u_cpu_alu_sub_swap_xor_direction_load_op (
      .clk(clk), .nrst(nrst), .op_valid(op_valid), .op(op),
      .file_addr(file_addr), .dest(dest), .literal(literal), .busy(busy),
      .accumulator(accumulator), .carry_flag(carry_flag),
      .nibble_carry_flag(nibble_carry_flag), .zero_flag(zero_flag),
      .port_a_direction(port_a_direction),
      .port_b_direction(port_b_direction),
      .port_c_direction(port_c_direction), .done(done));
   // Free-running clock, 20 ns period
   always #10 clk = ~clk;
   // Prints the counts and the verdict, then ends the run
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // One request, entered 1 ns after an edge; waits for the done pulse
   task automatic run_op(input alu_pkg::op_t o, input logic [6:0] a,
                         input logic d, input logic [7:0] k);
      int n;
      n = 0;
      op_valid = 1'h1;
      op = o;
      file_addr = a;
      dest = d;
      literal = k;
      @(posedge clk);
      #1 op_valid = 1'h0;
      `CHK(busy, 1'h1)
      // Bounded wait: a lost done must not hang the run
      while (done !== 1'h1 && n < 8) begin
         @(posedge clk);
         #1 n++;
      end
      // Judged on done itself, so a late done on the last try is not flagged here; the check of n below fails it
      if (done !== 1'h1) begin
         `CHK(done, 1'h1)
         final_report();
      end
      `CHK(n, 1)
   endtask
   // Accumulator is set by an immediate XOR against the known value
   task automatic set_acc(input logic [7:0] v);
      run_op(alu_pkg::xor_immediate_op, 7'h00, 1'h0, exp_acc ^ v);
      exp_acc = v;
      `CHK(accumulator, exp_acc)
      `CHK(zero_flag, 1'(v == 8'h00))
   endtask
   // Unwritten RAM reads as unknown and no XOR cancels an unknown, so the
   // cell is seeded through the hierarchy before the XOR pair
   task automatic load_file(input logic [6:0] a, input logic [7:0] v);
      u_cpu_alu_sub_swap_xor_direction_load_op.u_file.mem[a] = 8'hC3;
      set_acc(v);
      run_op(alu_pkg::xor_register_op, a, alu_pkg::DEST_ACC, 8'h00);
      `CHK(accumulator, v ^ 8'hC3)
      run_op(alu_pkg::xor_register_op, a, alu_pkg::DEST_FILE, 8'h00);
      `CHK(zero_flag, 1'(v == 8'h00))
      run_op(alu_pkg::nibble_exchange_op, a, alu_pkg::DEST_ACC, 8'h00);
      exp_acc = {v[3:0], v[7:4]};
      `CHK(accumulator, exp_acc)
   endtask
   // Values straight out of reset
   task automatic test_reset();
      `CHK({accumulator, carry_flag, nibble_carry_flag, zero_flag}, 11'h0)
      `CHK({port_a_direction, port_b_direction}, 16'hFFFF)
      `CHK(port_c_direction, alu_pkg::DIR_RESET)
      `CHK({done, busy}, 2'h0)
      $display("test reset done");
   endtask
   // Immediate XOR to nonzero and to zero; carry must not move
   task automatic test_xor_imm();
      set_acc(8'h5A);
      set_acc(8'h00);
      `CHK(carry_flag, 1'h0)
      $display("test xor immediate done");
   endtask
   // Each selector loads its own port; 4 is outside the range and is
   // tried with a zero accumulator so a cleared zero flag would show
   task automatic test_dir();
      logic [7:0] ed [4];
      int i;
      ed = '{8'hFF, 8'hFF, 8'hFF, 8'hFF};
      for (i = 0; i < 4; i++) begin
         set_acc(8'(i == 3 ? 0 : 8'h11 * (i + 1)));
         run_op(alu_pkg::direction_load_op, 7'(i == 3 ? 4 : 5 + i),
                1'h0, 8'h00);
         if (i < 3) begin
            ed[i] = exp_acc;
         end
         `CHK({port_a_direction, port_b_direction}, {ed[0], ed[1]})
         `CHK(port_c_direction, ed[2])
         `CHK(zero_flag, 1'(i == 3))
      end
      $display("test direction load done");
   endtask
   // Swap to file while zero is set, then read it back
   task automatic test_swap();
      load_file(7'h09, 8'h3C);
      set_acc(8'h00);
      run_op(alu_pkg::nibble_exchange_op, 7'h09, alu_pkg::DEST_FILE, 8'h00);
      `CHK(accumulator, 8'h00)
      run_op(alu_pkg::nibble_exchange_op, 7'h09, alu_pkg::DEST_ACC, 8'h00);
      `CHK(accumulator, 8'h3C)
      `CHK({carry_flag, zero_flag}, 2'h1)
      exp_acc = 8'h3C;
      $display("test swap done");
   endtask
   // Borrow chain at the top file address, both steerings
   task automatic test_sub();
      logic [7:0] sf [5];
      logic [7:0] sa [5];
      logic [8:0] t9;
      logic [4:0] t5;
      int i;
      sf = '{8'h50, 8'h50, 8'h10, 8'h00, 8'h7F};
      sa = '{8'h20, 8'h2F, 8'h10, 8'h01, 8'h00};
      for (i = 0; i < 5; i++) begin
         load_file(7'h7F, sf[i]);
         set_acc(sa[i]);
         `CHK(carry_flag, exp_c)
         t9 = {1'h0, sf[i]} - {1'h0, sa[i]} - {8'h00, ~exp_c};
         t5 = {1'h0, sf[i][3:0]} - {1'h0, sa[i][3:0]} - {4'h0, ~exp_c};
         exp_c = ~t9[8];
         run_op(alu_pkg::subtract_with_borrow_op, 7'h7F, 1'(i % 2), 8'h00);
         `CHK(carry_flag, exp_c)
         `CHK(nibble_carry_flag, ~t5[4])
         `CHK(zero_flag, 1'(t9[7:0] == 8'h00))
         if (i % 2 == 0) begin
            exp_acc = t9[7:0];
         end else begin
            `CHK(accumulator, exp_acc)
            run_op(alu_pkg::nibble_exchange_op, 7'h7F, 1'h0, 8'h00);
            exp_acc = {t9[3:0], t9[7:4]};
         end
         `CHK(accumulator, exp_acc)
      end
      $display("test subtract with borrow done");
   endtask
   // Main sequence
   initial begin
      repeat (6) @(posedge clk);
      #1 nrst = 1'h1;
      repeat (3) @(posedge clk);
      #1 test_reset();
      test_xor_imm();
      test_dir();
      test_swap();
      test_sub();
      final_report();
   end
endmodule
